// file: design/mig_pkg.sv
// Constants for the module mask, GPIO pin interrupt and NMI block
package mig_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] MIG_OFS_MASK_CLEAR = 8'h00;
    localparam logic [7:0] MIG_OFS_MASK_REG = 8'h04;
    localparam logic [7:0] MIG_OFS_SRC_RAW = 8'h08;
    localparam logic [7:0] MIG_OFS_SRC_MASKED = 8'h0C;
    localparam logic [7:0] MIG_OFS_GPIO_EN = 8'h10;
    localparam logic [7:0] MIG_OFS_NMI_CTRL = 8'h14;
    localparam logic [7:0] MIG_OFS_NMI_STAT = 8'h18;
    localparam logic [7:0] MIG_OFS_DETAIL_BASE = 8'h20;
    localparam logic [7:0] MIG_OFS_DETAIL_LAST = 8'h3C;
    localparam int MIG_DETAIL_NUM = 8;
    localparam int MIG_WORD_SHIFT = 2;

    // Reset values and field layouts
    localparam logic [31:0] MIG_MASK_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] MIG_MODULE_VALID = 32'h03FF_FFFF;
    localparam logic [31:0] MIG_GPIO_EN_VALID = 32'h030F_0707;
    localparam logic [31:0] MIG_ZERO = 32'h0000_0000;
    localparam int MIG_GPIO_MODULE_BIT = 25;
    localparam int MIG_GPIO_DETAIL_IDX = 7;
    localparam logic [31:0] MIG_DETAIL_VALID [MIG_DETAIL_NUM] = '{
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, MIG_GPIO_EN_VALID};

    // GPIO pins, order E0 E1 E2 E3 E4 E5 H0 H1 J0 K4 K5 E6
    localparam int MIG_GPIO_PINS = 12;
    localparam int MIG_GPIO_POS [MIG_GPIO_PINS] = '{0, 1, 2, 8, 9, 10, 16, 17, 18, 19, 24, 25};
    // Each group occupies one byte lane of the enable and detail words
    localparam logic [31:0] MIG_GROUP0 = 32'h0000_0007;
    localparam logic [31:0] MIG_GROUP1 = 32'h0000_0700;
    localparam logic [31:0] MIG_GROUP2 = 32'h000F_0000;
    localparam logic [31:0] MIG_GROUP3 = 32'h0300_0000;

    // NMI control and status fields
    localparam int MIG_CTRL_EDGE_RISE = 0;
    localparam int MIG_CTRL_BLOCK_OVR = 1;
    localparam int MIG_CTRL_MASK_UPD = 2;
    localparam logic [31:0] MIG_CTRL_VALID = 32'h0000_0007;
    localparam int MIG_STAT_PENDING = 0;
    localparam int MIG_STAT_HOLD = 1;
    localparam int MIG_STAT_GROUP_LSB = 4;

    // Priority levels
    localparam logic [4:0] MIG_LVL_NMI = 5'h10;
    localparam logic [4:0] MIG_LVL_NONE = 5'h00;
    localparam logic [4:0] MIG_LVL_MODULE = 5'h01;
    localparam logic [3:0] MIG_NMI_MASK_LEVEL = 4'hF;

    // Edge-select change quiet time
    localparam int MIG_CLK_PERIOD_NS = 50;
    localparam int MIG_NMI_QUIET_NS = 300;
    localparam int MIG_NMI_QUIET_CYC = (MIG_NMI_QUIET_NS + MIG_CLK_PERIOD_NS - 1) / MIG_CLK_PERIOD_NS;
    localparam logic [2:0] MIG_NMI_QUIET_LOAD = 3'(MIG_NMI_QUIET_CYC);

endpackage : mig_pkg

// file: design/mig_irq_ctrl.sv
// Module mask, detailed sources, GPIO pin interrupts and NMI detection
//
// Summary of operation
// - Mask-clear register is write-only; each 1 written unmasks that module.
// - Mask-clear reads as zero; software keeps bits 31 to 26 zero.
// - Mask-clear bits 25 to 17 map GPIO, flash, audio, card, serial, PCI.
// - Eight read-only detail registers show causes regardless of module mask.
// - Module enables gate whether each detail register's bits operate.
// - Reserved detail bits always read zero.
// - Detail registers 0..7: timer, clock, FIFO serial, DMA, PCI, card, flash, GPIO.
// - GPIO pin interrupts are active-low level requests.
// - Pins form four groups: E0-2, E3-5, H0 H1 J0 K4, K5 E6.
// - GPIO enable bit map as listed; 1 enables; reserved bits read zero.
// - Enabled GPIO pins merge into one module bit; detail 7 names the pin.
// - NMI 16 highest down to 1; level 0 means no request.
// - NMI at level 16 accepted unless blocked; sleep overrides the block.
// - A control bit lets NMI pass while the block bit is set.
// - NMI pin is edge detected; control bit picks rising or falling.
// - After an edge-select change, NMI detection pauses six bus clocks.
// - With mask update set, NMI acceptance loads mask level 15.
// - Module mask register resets to all ones.
// - Masked module sources are not signalled to the processor.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module mig_irq_ctrl
    import mig_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] module_req_in,
    input wire logic [7:0] module_enable_in,
    input wire logic [6:0][31:0] detail_cause_in,
    input wire logic [11:0] gpio_pin_b,
    input wire logic nmi_pin,
    input wire logic processor_block_bit,
    input wire logic sleep_mode,
    input wire logic [4:0] ext_level_in,
    output logic module_irq,
    output logic [4:0] irq_level,
    output logic nmi_accept,
    output logic mask_level_load,
    output logic [3:0] processor_mask_level
);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic [31:0] merge_gpio(input logic [11:0] pins);
        logic [31:0] w;
        w = MIG_ZERO;
        for (int i = 0; i < MIG_GPIO_PINS; i++)
        begin
            w[MIG_GPIO_POS[i]] = pins[i];
        end
        merge_gpio = w;
    endfunction : merge_gpio

    // Registers
    logic [31:0] mask_r;
    logic [31:0] mask_nxt;
    logic [31:0] gpio_en_r;
    logic [31:0] nmi_ctrl_r;
    logic [31:0] detail_r [MIG_DETAIL_NUM];
    logic [31:0] src_raw_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [11:0] gpio_s1_r;
    logic [11:0] gpio_s2_r;
    logic nmi_s1_r;
    logic nmi_s2_r;
    logic nmi_prev_r;
    logic [2:0] quiet_r;
    logic [2:0] quiet_nxt;
    logic nmi_pend_r;
    logic nmi_pend_nxt;
    logic module_irq_r;
    logic [4:0] irq_level_r;
    logic nmi_accept_r;
    logic mask_load_r;
    logic [3:0] mask_level_r;

    // Bus decode
    wire setup = psel & ~penable;
    wire wr_take = psel & penable & pready_r & pwrite;
    wire sel_clr = hit(paddr, MIG_OFS_MASK_CLEAR);
    wire sel_mask = hit(paddr, MIG_OFS_MASK_REG);
    wire sel_raw = hit(paddr, MIG_OFS_SRC_RAW);
    wire sel_masked = hit(paddr, MIG_OFS_SRC_MASKED);
    wire sel_gpio = hit(paddr, MIG_OFS_GPIO_EN);
    wire sel_ctrl = hit(paddr, MIG_OFS_NMI_CTRL);
    wire sel_stat = hit(paddr, MIG_OFS_NMI_STAT);
    wire sel_det = (paddr >= MIG_OFS_DETAIL_BASE) && (paddr <= MIG_OFS_DETAIL_LAST)
        && (paddr[1:0] == 2'b00);
    wire [7:0] det_ofs = paddr - MIG_OFS_DETAIL_BASE;
    wire [2:0] det_idx = det_ofs[4:2];
    wire mapped = sel_clr | sel_mask | sel_raw | sel_masked | sel_gpio | sel_ctrl
        | sel_stat | sel_det;

    // GPIO pins: synced, inverted, enabled
    wire [31:0] gpio_active = merge_gpio(~gpio_s2_r);
    wire [31:0] gpio_cause = gpio_active & gpio_en_r & MIG_GPIO_EN_VALID;
    wire gpio_any = |gpio_cause;
    wire [3:0] gpio_group = {|(gpio_cause & MIG_GROUP3), |(gpio_cause & MIG_GROUP2),
        |(gpio_cause & MIG_GROUP1), |(gpio_cause & MIG_GROUP0)};

    // Module sources and masking
    wire [31:0] gpio_bit = MIG_ZERO | (32'(gpio_any) << MIG_GPIO_MODULE_BIT);
    wire [31:0] src_raw_nxt = (module_req_in | gpio_bit) & MIG_MODULE_VALID;
    wire [31:0] src_masked = src_raw_r & ~mask_r;

    // Mask update: write-one-to-clear and write-one-to-set
    always_comb
    begin
        mask_nxt = mask_r;
        if (wr_take && sel_clr)
        begin
            mask_nxt = mask_r & ~(pwdata & MIG_MODULE_VALID);
        end
        else if (wr_take && sel_mask)
        begin
            mask_nxt = mask_r | (pwdata & MIG_MODULE_VALID);
        end
    end

    // Read mux
    wire [31:0] rd_det = detail_r[det_idx];
    wire [31:0] rd_stat = MIG_ZERO | (32'(nmi_pend_r) << MIG_STAT_PENDING)
        | (32'(quiet_r != 3'h0) << MIG_STAT_HOLD) | (32'(gpio_group) << MIG_STAT_GROUP_LSB);
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = MIG_ZERO;
        if (sel_clr)
        begin
            rd_val = MIG_ZERO;
        end
        else if (sel_mask)
        begin
            rd_val = mask_nxt;
        end
        else if (sel_raw)
        begin
            rd_val = src_raw_r;
        end
        else if (sel_masked)
        begin
            rd_val = src_masked;
        end
        else if (sel_gpio)
        begin
            rd_val = gpio_en_r;
        end
        else if (sel_ctrl)
        begin
            rd_val = nmi_ctrl_r;
        end
        else if (sel_stat)
        begin
            rd_val = rd_stat;
        end
        else if (sel_det)
        begin
            rd_val = rd_det;
        end
    end

    // APB answer: one wait-free access phase, pready on the second cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= MIG_ZERO;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r <= (setup && !pwrite) ? rd_val : MIG_ZERO;
        end
    end

    // Software registers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mask_r <= MIG_MASK_RESET;
            gpio_en_r <= MIG_ZERO;
            nmi_ctrl_r <= MIG_ZERO;
        end
        else
        begin
            mask_r <= mask_nxt;
            if (wr_take && sel_gpio)
            begin
                gpio_en_r <= pwdata & MIG_GPIO_EN_VALID;
            end
            if (wr_take && sel_ctrl)
            begin
                nmi_ctrl_r <= pwdata & MIG_CTRL_VALID;
            end
        end
    end

    // Detail registers follow their causes while the module is enabled
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < MIG_DETAIL_NUM; i++)
            begin
                detail_r[i] <= MIG_ZERO;
            end
            src_raw_r <= MIG_ZERO;
        end
        else
        begin
            for (int i = 0; i < MIG_GPIO_DETAIL_IDX; i++)
            begin
                detail_r[i] <= module_enable_in[i] ? (detail_cause_in[i] & MIG_DETAIL_VALID[i])
                    : MIG_ZERO;
            end
            detail_r[MIG_GPIO_DETAIL_IDX] <= module_enable_in[MIG_GPIO_DETAIL_IDX] ? gpio_cause
                : MIG_ZERO;
            src_raw_r <= src_raw_nxt;
        end
    end

    // Pin synchronisers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gpio_s1_r <= 12'hFFF;
            gpio_s2_r <= 12'hFFF;
            nmi_s1_r <= 1'b1;
            nmi_s2_r <= 1'b1;
            nmi_prev_r <= 1'b1;
        end
        else
        begin
            gpio_s1_r <= gpio_pin_b;
            gpio_s2_r <= gpio_s1_r;
            nmi_s1_r <= nmi_pin;
            nmi_s2_r <= nmi_s1_r;
            nmi_prev_r <= nmi_s2_r;
        end
    end

    // NMI edge detect with quiet time after an edge-select change
    wire edge_rise = nmi_ctrl_r[MIG_CTRL_EDGE_RISE];
    wire nmi_edge = edge_rise ? (nmi_s2_r & ~nmi_prev_r) : (~nmi_s2_r & nmi_prev_r);
    wire sel_change = wr_take && sel_ctrl && (pwdata[MIG_CTRL_EDGE_RISE] != edge_rise);
    wire quiet = (quiet_r != 3'h0);
    wire nmi_detect = nmi_edge & ~quiet;
    wire nmi_allowed = ~processor_block_bit | sleep_mode
        | nmi_ctrl_r[MIG_CTRL_BLOCK_OVR];
    wire nmi_take = nmi_pend_r & nmi_allowed;

    always_comb
    begin
        quiet_nxt = quiet ? quiet_r - 3'h1 : quiet_r;
        if (sel_change)
        begin
            quiet_nxt = MIG_NMI_QUIET_LOAD;
        end
        nmi_pend_nxt = nmi_pend_r;
        if (nmi_take)
        begin
            nmi_pend_nxt = 1'b0;
        end
        if (nmi_detect)
        begin
            nmi_pend_nxt = 1'b1; // New edge wins over acceptance
        end
    end

    // Priority ranking: NMI, then external level, then modules
    wire [4:0] mod_level = (|src_masked) ? MIG_LVL_MODULE : MIG_LVL_NONE;
    wire [4:0] best_other = (ext_level_in > mod_level) ? ext_level_in : mod_level;
    wire [4:0] level_nxt = nmi_pend_nxt ? MIG_LVL_NMI : best_other;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            quiet_r <= 3'h0;
            nmi_pend_r <= 1'b0;
            module_irq_r <= 1'b0;
            irq_level_r <= MIG_LVL_NONE;
            nmi_accept_r <= 1'b0;
            mask_load_r <= 1'b0;
            mask_level_r <= 4'h0;
        end
        else
        begin
            quiet_r <= quiet_nxt;
            nmi_pend_r <= nmi_pend_nxt;
            module_irq_r <= |(src_raw_nxt & ~mask_nxt);
            irq_level_r <= level_nxt;
            nmi_accept_r <= nmi_take;
            mask_load_r <= nmi_take & nmi_ctrl_r[MIG_CTRL_MASK_UPD];
            if (nmi_take && nmi_ctrl_r[MIG_CTRL_MASK_UPD])
            begin
                mask_level_r <= MIG_NMI_MASK_LEVEL;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign module_irq = module_irq_r;
    assign irq_level = irq_level_r;
    assign nmi_accept = nmi_accept_r;
    assign mask_level_load = mask_load_r;
    assign processor_mask_level = mask_level_r;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_clear_read_zero: assert property (
        (psel && penable && pready && !pwrite && sel_clr) |-> (prdata == MIG_ZERO))
        else $error("mask clear read not zero");

    chk_clear_unmasks: assert property (
        (wr_take && sel_clr) |=> ((mask_r & $past(pwdata) & MIG_MODULE_VALID) == MIG_ZERO))
        else $error("mask clear write left bits masked");

    chk_clear_zero_keeps: assert property (
        (wr_take && sel_clr) |=> ((mask_r | $past(pwdata)) == ($past(mask_r) | $past(pwdata))))
        else $error("mask clear write of zero changed mask");

    chk_masked_silent: assert property (
        module_irq == (src_masked != MIG_ZERO))
        else $error("masked source reached processor");

    chk_gpio_level: assert property (
        (gpio_en_r[MIG_GPIO_POS[0]] && module_enable_in[MIG_GPIO_DETAIL_IDX]
            && !gpio_s2_r[0]) |=> detail_r[MIG_GPIO_DETAIL_IDX][MIG_GPIO_POS[0]])
        else $error("enabled low GPIO pin not reported");

    chk_gpio_merge: assert property (
        gpio_any |=> src_raw_r[MIG_GPIO_MODULE_BIT])
        else $error("GPIO request missing from module source");

    chk_gpio_reserved: assert property (
        (gpio_en_r & ~MIG_GPIO_EN_VALID) == MIG_ZERO)
        else $error("GPIO enable reserved bit set");

    chk_nmi_quiet: assert property (
        sel_change |=> !nmi_detect [*6])
        else $error("NMI detected during quiet time");

    chk_nmi_accept: assert property (
        (nmi_pend_r && !processor_block_bit) |=> nmi_accept)
        else $error("unblocked NMI not accepted");

    chk_nmi_blocked: assert property (
        (nmi_pend_r && processor_block_bit && !sleep_mode
            && !nmi_ctrl_r[MIG_CTRL_BLOCK_OVR]) |=> !nmi_accept)
        else $error("blocked NMI accepted");

    chk_nmi_level: assert property (
        (nmi_take && nmi_ctrl_r[MIG_CTRL_MASK_UPD])
            |=> (mask_level_load && processor_mask_level == MIG_NMI_MASK_LEVEL))
        else $error("NMI acceptance did not load level 15");

    chk_nmi_top: assert property (
        nmi_pend_r |-> (irq_level == MIG_LVL_NMI))
        else $error("pending NMI not at level 16");

endmodule : mig_irq_ctrl

`default_nettype wire

// file: tb/mig_core_model.sv
// Processor core stand-in on the far side of the interrupt block
`timescale 1ns/10ps
`default_nettype none

module mig_core_model
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic block_cmd,
    input wire logic sleep_cmd,
    input wire logic nmi_accept,
    output logic processor_block_bit,
    output logic sleep_mode,
    output logic [7:0] accept_count
);
    // Core state moves on its own clock edge, one cycle behind the command
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            processor_block_bit <= 1'b0;
            sleep_mode <= 1'b0;
            accept_count <= 8'h00;
        end
        else
        begin
            processor_block_bit <= block_cmd;
            sleep_mode <= sleep_cmd;
            accept_count <= accept_count + {7'h00, nmi_accept};
        end
    end
endmodule : mig_core_model

`default_nettype wire

// file: tb/test_mig_irq_ctrl.sv
// Self-checking bench for the module mask, GPIO and NMI block
`timescale 1ns/10ps
`default_nettype none

module test_mig_irq_ctrl;
    import mig_pkg::*;
    logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, nmi_pin, bsy, slp;
    logic blk_cmd, slp_cmd, module_irq, nmi_accept, mask_level_load, rerr;
    logic [7:0] paddr, module_enable_in, acc_cnt;
    logic [31:0] pwdata, prdata, module_req_in, rdat;
    logic [6:0][31:0] detail_cause_in;
    logic [11:0] gpio_pin_b;
    logic [4:0] ext_level_in, irq_level;
    logic [3:0] processor_mask_level;
    int bad_count, n_tests;

    mig_irq_ctrl mig_irq_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .module_req_in(module_req_in),
        .module_enable_in(module_enable_in), .detail_cause_in(detail_cause_in),
        .gpio_pin_b(gpio_pin_b), .nmi_pin(nmi_pin), .processor_block_bit(bsy),
        .sleep_mode(slp), .ext_level_in(ext_level_in), .module_irq(module_irq),
        .irq_level(irq_level), .nmi_accept(nmi_accept), .mask_level_load(mask_level_load),
        .processor_mask_level(processor_mask_level));
    mig_core_model mig_core_model_inst (.ref_clk(ref_clk), .rst_b(rst_b), .block_cmd(blk_cmd),
        .sleep_cmd(slp_cmd), .nmi_accept(nmi_accept), .processor_block_bit(bsy),
        .sleep_mode(slp), .accept_count(acc_cnt));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task stop_test();
        $display("mismatches %0d comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Entered right after a rising edge; leaves one idle edge behind
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge ref_clk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        if (i >= 50)
            bad_count++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task wait_acc(input logic exp, input logic exp_ld);
        logic seen, ld;
        seen = 1'b0;
        ld = 1'b0;
        repeat (20)
        begin
            @(posedge ref_clk);
            if (nmi_accept === 1'b1)
            begin
                seen = 1'b1;
                ld = mask_level_load;
            end
        end
        chk({31'h0, seen}, {31'h0, exp});
        if (exp)
            chk({31'h0, ld}, {31'h0, exp_ld});
    endtask : wait_acc

    task t_reset_vals();
        apb(1'b0, MIG_OFS_MASK_REG, MIG_ZERO);
        chk(rdat, MIG_MASK_RESET);
        apb(1'b0, MIG_OFS_MASK_CLEAR, MIG_ZERO);
        chk(rdat, MIG_ZERO);
        apb(1'b0, MIG_OFS_GPIO_EN, MIG_ZERO);
        chk(rdat, MIG_ZERO);
        apb(1'b0, 8'h22, MIG_ZERO);
        chk({31'h0, rerr}, 32'h0000_0001);
        chk(rdat, MIG_ZERO);
        apb(1'b1, 8'h60, 32'hFFFF_FFFF);
        chk({31'h0, rerr}, 32'h0000_0001);
    endtask : t_reset_vals

    task t_mask_clear();
        apb(1'b1, MIG_OFS_MASK_CLEAR, 32'h02FE_0000);
        apb(1'b0, MIG_OFS_MASK_REG, MIG_ZERO);
        chk(rdat, 32'hFD01_FFFF);
        apb(1'b1, MIG_OFS_MASK_CLEAR, MIG_ZERO);
        apb(1'b0, MIG_OFS_MASK_REG, MIG_ZERO);
        chk(rdat, 32'hFD01_FFFF);
        apb(1'b0, MIG_OFS_MASK_CLEAR, MIG_ZERO);
        chk(rdat, MIG_ZERO);
    endtask : t_mask_clear

    task t_module();
        module_req_in <= 32'h0002_0000;
        repeat (3) @(posedge ref_clk);
        chk({31'h0, module_irq}, 32'h0000_0001);
        chk({27'h0, irq_level}, {27'h0, MIG_LVL_MODULE});
        ext_level_in <= 5'h05;
        repeat (3) @(posedge ref_clk);
        chk({27'h0, irq_level}, 32'h0000_0005);
        ext_level_in <= 5'h00;
        module_req_in <= 32'hFD00_0000;
        repeat (3) @(posedge ref_clk);
        chk({31'h0, module_irq}, MIG_ZERO);
        apb(1'b0, MIG_OFS_SRC_RAW, MIG_ZERO);
        chk(rdat, 32'h0100_0000);
        apb(1'b0, MIG_OFS_SRC_MASKED, MIG_ZERO);
        chk(rdat, MIG_ZERO);
        module_req_in <= 32'h0002_0000;
        apb(1'b1, MIG_OFS_MASK_REG, 32'h0002_0000);
        apb(1'b0, MIG_OFS_MASK_REG, MIG_ZERO);
        chk(rdat, 32'hFD03_FFFF);
        chk({31'h0, module_irq}, MIG_ZERO);
        apb(1'b1, MIG_OFS_MASK_CLEAR, 32'h0002_0000);
        chk({31'h0, module_irq}, 32'h0000_0001);
        apb(1'b0, MIG_OFS_MASK_REG, MIG_ZERO);
        chk(rdat, 32'hFD01_FFFF);
        module_req_in <= MIG_ZERO;
    endtask : t_module

    task t_detail();
        for (int i = 0; i < 7; i++)
            detail_cause_in[i] <= 32'(32'h1111_1111 * (i + 1));
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, MIG_OFS_DETAIL_BASE + 8'(4 * i), MIG_ZERO);
            chk(rdat, 32'(32'h1111_1111 * (i + 1)));
        end
        module_enable_in <= 8'h00;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, MIG_OFS_DETAIL_BASE + 8'(4 * i), MIG_ZERO);
            chk(rdat, MIG_ZERO);
        end
        module_enable_in <= 8'hFF;
    endtask : t_detail

    task t_gpio();
        apb(1'b1, MIG_OFS_GPIO_EN, 32'hFFFF_FFFF);
        apb(1'b0, MIG_OFS_GPIO_EN, MIG_ZERO);
        chk(rdat, MIG_GPIO_EN_VALID);
        gpio_pin_b <= 12'h7FF;
        repeat (5) @(posedge ref_clk);
        apb(1'b0, MIG_OFS_DETAIL_LAST, MIG_ZERO);
        chk(rdat, 32'h0200_0000);
        apb(1'b0, MIG_OFS_SRC_RAW, MIG_ZERO);
        chk(rdat, 32'h0200_0000);
        chk({31'h0, module_irq}, 32'h0000_0001);
        apb(1'b0, MIG_OFS_NMI_STAT, MIG_ZERO);
        chk((rdat >> 4) & 32'h0000_000F, 32'h0000_0008);
        apb(1'b1, MIG_OFS_GPIO_EN, 32'h0000_0001);
        apb(1'b0, MIG_OFS_DETAIL_LAST, MIG_ZERO);
        chk(rdat, MIG_ZERO);
        gpio_pin_b <= 12'hFFE;
        repeat (5) @(posedge ref_clk);
        apb(1'b0, MIG_OFS_NMI_STAT, MIG_ZERO);
        chk((rdat >> 4) & 32'h0000_000F, 32'h0000_0001);
        gpio_pin_b <= 12'hFFF;
        apb(1'b1, MIG_OFS_GPIO_EN, MIG_ZERO);
    endtask : t_gpio

    task t_nmi();
        apb(1'b1, MIG_OFS_NMI_CTRL, 32'h0000_0004);
        repeat (8) @(posedge ref_clk);
        nmi_pin <= 1'b0;
        wait_acc(1'b1, 1'b1);
        chk({28'h0, processor_mask_level}, {28'h0, MIG_NMI_MASK_LEVEL});
        blk_cmd <= 1'b1;
        repeat (2) @(posedge ref_clk);
        nmi_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        nmi_pin <= 1'b0;
        wait_acc(1'b0, 1'b0);
        chk({27'h0, irq_level}, {27'h0, MIG_LVL_NMI});
        slp_cmd <= 1'b1;
        wait_acc(1'b1, 1'b1);
        slp_cmd <= 1'b0;
        apb(1'b1, MIG_OFS_NMI_CTRL, 32'h0000_0002);
        repeat (8) @(posedge ref_clk);
        nmi_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        nmi_pin <= 1'b0;
        wait_acc(1'b1, 1'b0);
        blk_cmd <= 1'b0;
        // Edge arrives inside the quiet time after the select change
        apb(1'b1, MIG_OFS_NMI_CTRL, 32'h0000_0001);
        nmi_pin <= 1'b1;
        wait_acc(1'b0, 1'b0);
        nmi_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        nmi_pin <= 1'b1;
        wait_acc(1'b1, 1'b0);
        chk({24'h0, acc_cnt}, 32'h0000_0004);
    endtask : t_nmi

    initial
    begin
        bad_count = 0;
        n_tests = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        module_req_in = 32'h0000_0000;
        module_enable_in = 8'hFF;
        detail_cause_in = '0;
        gpio_pin_b = 12'hFFF;
        nmi_pin = 1'b1;
        blk_cmd = 1'b0;
        slp_cmd = 1'b0;
        ext_level_in = 5'h00;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_reset_vals();
        t_mask_clear();
        t_module();
        t_detail();
        t_gpio();
        t_nmi();
        stop_test();
    end

    // Whole run needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        stop_test();
    end
endmodule : test_mig_irq_ctrl

`default_nettype wire
